// file: logic/eeprom_link_cfg.svh
// constants of the two-wire eeprom link: control byte layout, widths, timing
// assumes a 100 MHz system clock at both ends
`ifndef EEPROM_LINK_CFG_SVH
`define EEPROM_LINK_CFG_SVH

`define CLOCK_MHZ 100
// device-type code: value is arbitrary
`define DEV_TYPE_CODE 4'h5
`define CTRL_TYPE_MSB 7
`define CTRL_TYPE_LSB 4
`define CTRL_SEL_MSB 3
`define CTRL_SEL_LSB 1
`define CTRL_RW_BIT 0
`define BYTE_BITS 4'h8
`define WORD_ADDR_W 14
`define ADDR_HI_BITS 6
// internal programming cycle, in ms, and its cycle count
`define WRITE_CYCLE_MS 5
`define WRITE_CYCLE_CYCLES (`WRITE_CYCLE_MS * 1000 * 1000 * `CLOCK_MHZ / 1000)
// master serial clock quarter period: 2500 ns gives a 100 kHz bus
`define SCL_QUARTER_NS 2500
`define SCL_QUARTER_CYCLES (`SCL_QUARTER_NS * `CLOCK_MHZ / 1000)

`endif

// file: logic/eeprom_link_if.sv
// the two-wire bus: open-drain clock from the master end, data resolved from both ends
// assumes pull-ups, modelled by a released line reading one
`timescale 1ns/1ns
`default_nettype none
interface eeprom_link_if;
	logic m_scl_out;
	logic m_scl_oe;
	logic m_sda_out;
	logic m_sda_oe;
	logic d_sda_out;
	logic d_sda_oe;
	logic scl;
	logic sda;
	// wired-and of every enabled driver, pull-up otherwise
	assign scl = (m_scl_oe && !m_scl_out) ? 1'b0 : 1'b1;
	assign sda = ((m_sda_oe && !m_sda_out) || (d_sda_oe && !d_sda_out)) ? 1'b0 : 1'b1;
	modport device(input scl, input sda, output d_sda_out, output d_sda_oe);
	modport master(input scl, input sda, output m_scl_out, output m_scl_oe, output m_sda_out, output m_sda_oe);
endinterface
`default_nettype wire

// file: logic/eeprom_link_pkg.sv
// types shared by both ends of the two-wire eeprom link
// assumes eeprom_link_cfg.svh holds the numbers
package eeprom_link_pkg;
	// slave byte-level states, gray along idle-rx-ack-tx-mack
	typedef enum logic [2:0] {
		st_idle = 3'h0,
		st_rx = 3'h1,
		st_ack = 3'h3,
		st_tx = 3'h2,
		st_mack = 3'h6
	} slave_state_t;
	// master states
	typedef enum logic [0:0] {
		ms_idle = 1'h0,
		ms_busy = 1'h1
	} master_state_t;
	// master bus operations
	typedef enum logic [1:0] {
		op_start = 2'h0,
		op_stop = 2'h1,
		op_write = 2'h2,
		op_read = 2'h3
	} bus_op_t;
endpackage

// file: logic/eeprom_master_end.sv
// bus master end: makes scl by a divider, performs start, stop, byte write, byte read
// assumes one command at a time on the user side, taken while cmd_ready is high
`include "eeprom_link_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module eeprom_master_end (
	input wire logic clock,
	input wire logic rst_n,
	eeprom_link_if.master link,
	input wire logic cmd_valid,
	input wire eeprom_link_pkg::bus_op_t cmd_op,
	input wire logic [7:0] cmd_wdata,
	input wire logic cmd_nack,
	output logic cmd_ready,
	output logic done,
	output logic [7:0] read_byte,
	output logic ack_seen
);
	localparam logic [7:0] QUARTER = 8'(`SCL_QUARTER_CYCLES);

	logic [1:0] sda_sync_reg;
	logic sda_s;
	logic [7:0] div_reg;
	logic tick;
	eeprom_link_pkg::master_state_t state_reg;
	eeprom_link_pkg::bus_op_t op_reg;
	logic [1:0] quarter_reg;
	logic [3:0] bit_idx_reg;
	logic [7:0] shift_reg;
	logic nack_reg;
	logic scl_oe_reg;
	logic sda_oe_reg;
	logic is_write;

	// sda is a pin: two flops before use
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sda_sync_reg <= 2'h3;
		end else begin
			sda_sync_reg <= {sda_sync_reg[0], link.sda};
		end
	end
	assign sda_s = sda_sync_reg[1];

	// quarter-period divider, restarted with each command
	always_ff @(posedge clock) begin
		if (!rst_n || state_reg == eeprom_link_pkg::ms_idle || tick) begin
			div_reg <= 8'h00;
		end else begin
			div_reg <= div_reg + 8'h01;
		end
	end
	assign tick = (state_reg == eeprom_link_pkg::ms_busy) && (div_reg == QUARTER - 8'h01);
	assign is_write = (op_reg == eeprom_link_pkg::op_write);

	// sequencer: every operation is a run of quarter periods
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_reg <= eeprom_link_pkg::ms_idle;
			op_reg <= eeprom_link_pkg::op_start;
			quarter_reg <= 2'h0;
			bit_idx_reg <= 4'h0;
			shift_reg <= 8'h00;
			nack_reg <= 1'b0;
			scl_oe_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
			cmd_ready <= 1'b1;
			done <= 1'b0;
			read_byte <= 8'h00;
			ack_seen <= 1'b0;
		end else begin
			done <= 1'b0;
			if (state_reg == eeprom_link_pkg::ms_idle) begin
				// user starts only from idle bus
				if (cmd_valid) begin
					state_reg <= eeprom_link_pkg::ms_busy;
					op_reg <= cmd_op;
					shift_reg <= cmd_wdata;
					nack_reg <= cmd_nack;
					quarter_reg <= 2'h0;
					bit_idx_reg <= 4'h0;
					cmd_ready <= 1'b0;
				end
			end else if (tick) begin
				quarter_reg <= quarter_reg + 2'h1;
				case (op_reg)
					eeprom_link_pkg::op_start: begin
						case (quarter_reg)
							2'h0: sda_oe_reg <= 1'b0;
							2'h1: scl_oe_reg <= 1'b0;
							2'h2: sda_oe_reg <= 1'b1;
							default: begin
								scl_oe_reg <= 1'b1;
								state_reg <= eeprom_link_pkg::ms_idle;
								cmd_ready <= 1'b1;
								done <= 1'b1;
							end
						endcase
					end
					eeprom_link_pkg::op_stop: begin
						case (quarter_reg)
							2'h0: sda_oe_reg <= 1'b1;
							2'h1: scl_oe_reg <= 1'b0;
							2'h2: sda_oe_reg <= 1'b0;
							default: begin
								state_reg <= eeprom_link_pkg::ms_idle;
								cmd_ready <= 1'b1;
								done <= 1'b1;
							end
						endcase
					end
					default: begin
						case (quarter_reg)
							2'h0: begin
								if (bit_idx_reg != `BYTE_BITS) begin
									sda_oe_reg <= is_write && !shift_reg[7];
								end else begin
									sda_oe_reg <= !is_write && !nack_reg;
								end
							end
							2'h1: scl_oe_reg <= 1'b0;
							2'h2: begin
								if (bit_idx_reg != `BYTE_BITS) begin
									shift_reg <= {shift_reg[6:0], 1'b0};
									read_byte <= {read_byte[6:0], sda_s};
								end else begin
									ack_seen <= !sda_s;
								end
							end
							default: begin
								scl_oe_reg <= 1'b1;
								if (bit_idx_reg == `BYTE_BITS) begin
									sda_oe_reg <= 1'b0;
									state_reg <= eeprom_link_pkg::ms_idle;
									cmd_ready <= 1'b1;
									done <= 1'b1;
								end else begin
									bit_idx_reg <= bit_idx_reg + 4'h1;
								end
							end
						endcase
					end
				endcase
			end
		end
	end

	// open drain on both lines
	assign link.m_scl_out = 1'b0;
	assign link.m_scl_oe = scl_oe_reg;
	assign link.m_sda_out = 1'b0;
	assign link.m_sda_oe = sda_oe_reg;
endmodule
`default_nettype wire

// file: logic/eeprom_slave_end.sv
// slave front end of a two-wire serial eeprom: framing, control byte, address, acks
// assumes the bus master makes scl; array and page buffer sit on the user side
//
// What this block does
// - first byte after start is control byte
// - select bits must equal the select pins
// - last control bit one reads, zero writes
// - two address bytes, high first, fourteen kept
// - matching control byte acked, then read/write
// - no acks during programming cycle
// - sda falling with scl high is start
// - sda rising with scl high is stop
// - sda changes only while scl low
// - master starts only from idle bus
// - every received byte after an acked control byte acked on ninth clock
// - ack holds sda low through scl high
// - master nack ends read, sda released
// - write-protect high blocks writes, not reads
// - sda only pulled low or released
// - pinless variant master sends low bits zero
// - slave only; master owns clock and framing
// - any number of bytes per transaction
// - select pins settled before bus use
// - write-protect sampled at write stop
// - stop after write data starts write cycle
`include "eeprom_link_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module eeprom_slave_end #(
	parameter int unsigned WRITE_CYCLE_CYCLES = `WRITE_CYCLE_CYCLES
) (
	input wire logic clock,
	input wire logic rst_n,
	eeprom_link_if.device link,
	input wire logic select_pin_low,
	input wire logic select_pin_mid,
	input wire logic select_pin_high,
	input wire logic write_protect,
	input wire logic [7:0] read_data,
	output logic [`WORD_ADDR_W-1:0] word_address_bits,
	output logic [7:0] write_data,
	output logic write_data_strobe,
	output logic read_data_strobe,
	output logic write_cycle_start,
	output logic write_blocked,
	output logic busy
);
	localparam logic [3:0] TYPE_CODE = `DEV_TYPE_CODE;

	logic [5:0] pin_raw;
	logic [5:0] pin_meta_reg;
	logic [5:0] pin_sync_reg;
	logic scl_s;
	logic sda_s;
	logic scl_prev_reg;
	logic sda_prev_reg;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	logic [2:0] sel_s;
	logic wp_s;

	eeprom_link_pkg::slave_state_t state_reg;
	logic [3:0] bit_cnt_reg;
	logic [7:0] shift_reg;
	logic [1:0] byte_idx_reg;
	logic read_mode_reg;
	logic more_reg;
	logic wrote_data_reg;
	logic sda_oe_reg;
	logic [31:0] prog_cnt_reg;
	logic match;
	logic give_ack;

	assign pin_raw = {link.scl, link.sda, select_pin_high, select_pin_mid, select_pin_low, write_protect};

	// two flops on every pin before any logic looks at it
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_sync
			always_ff @(posedge clock) begin
				if (!rst_n) begin
					pin_meta_reg[gi] <= 1'b1;
					pin_sync_reg[gi] <= 1'b1;
				end else begin
					pin_meta_reg[gi] <= pin_raw[gi];
					pin_sync_reg[gi] <= pin_meta_reg[gi];
				end
			end
		end
	endgenerate

	assign scl_s = pin_sync_reg[5];
	assign sda_s = pin_sync_reg[4];
	// select pins are expected steady before the first frame
	assign sel_s = pin_sync_reg[3:1];
	assign wp_s = pin_sync_reg[0];

	// previous synced levels for edge detection
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end else begin
			scl_prev_reg <= scl_s;
			sda_prev_reg <= sda_s;
		end
	end

	// the slave never makes clock edges, it only follows them
	// scl edges followed
	assign scl_rise = scl_s && !scl_prev_reg;
	assign scl_fall = !scl_s && scl_prev_reg;
	assign start_seen = scl_s && scl_prev_reg && sda_prev_reg && !sda_s;
	assign stop_seen = scl_s && scl_prev_reg && !sda_prev_reg && sda_s;

	assign match = (shift_reg[`CTRL_TYPE_MSB:`CTRL_TYPE_LSB] == TYPE_CODE) &&
		(shift_reg[`CTRL_SEL_MSB:`CTRL_SEL_LSB] == sel_s);
	assign give_ack = !busy && ((byte_idx_reg != 2'h0) || match);

	// byte engine: receive, ack, transmit, master ack
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_reg <= eeprom_link_pkg::st_idle;
			bit_cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			byte_idx_reg <= 2'h0;
			read_mode_reg <= 1'b0;
			more_reg <= 1'b0;
			wrote_data_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
			word_address_bits <= '0;
			write_data <= 8'h00;
			write_data_strobe <= 1'b0;
			read_data_strobe <= 1'b0;
		end else begin
			write_data_strobe <= 1'b0;
			read_data_strobe <= 1'b0;
			// address moves on the cycle after each strobe, so the strobe shows the old one
			if (write_data_strobe || read_data_strobe) begin
				word_address_bits <= word_address_bits + 1'b1;
			end
			if (start_seen) begin
				state_reg <= eeprom_link_pkg::st_rx;
				bit_cnt_reg <= 4'h0;
				byte_idx_reg <= 2'h0;
				wrote_data_reg <= 1'b0;
				sda_oe_reg <= 1'b0;
			end else if (stop_seen) begin
				state_reg <= eeprom_link_pkg::st_idle;
				wrote_data_reg <= 1'b0;
				sda_oe_reg <= 1'b0;
			end else begin
				case (state_reg)
					eeprom_link_pkg::st_rx: begin
						if (scl_rise && bit_cnt_reg != `BYTE_BITS) begin
							shift_reg <= {shift_reg[6:0], sda_s};
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
						end else if (scl_fall && bit_cnt_reg == `BYTE_BITS) begin
							if (give_ack) begin
								sda_oe_reg <= 1'b1;
								state_reg <= eeprom_link_pkg::st_ack;
								if (byte_idx_reg != 2'h3) begin
									byte_idx_reg <= byte_idx_reg + 2'h1;
								end
								case (byte_idx_reg)
									2'h0: read_mode_reg <= shift_reg[`CTRL_RW_BIT];
									2'h1: word_address_bits[`WORD_ADDR_W-1:8] <= shift_reg[`ADDR_HI_BITS-1:0];
									2'h2: word_address_bits[7:0] <= shift_reg;
									default: begin
										write_data <= shift_reg;
										write_data_strobe <= 1'b1;
										wrote_data_reg <= 1'b1;
									end
								endcase
							end else begin
								state_reg <= eeprom_link_pkg::st_idle;
							end
						end
					end
					eeprom_link_pkg::st_ack: begin
						if (scl_fall) begin
							bit_cnt_reg <= 4'h0;
							if (read_mode_reg && byte_idx_reg == 2'h1) begin
								shift_reg <= read_data;
								sda_oe_reg <= !read_data[7];
								read_data_strobe <= 1'b1;
								state_reg <= eeprom_link_pkg::st_tx;
							end else begin
								sda_oe_reg <= 1'b0;
								state_reg <= eeprom_link_pkg::st_rx;
							end
						end
					end
					eeprom_link_pkg::st_tx: begin
						if (scl_fall) begin
							if (bit_cnt_reg == 4'h7) begin
								sda_oe_reg <= 1'b0;
								state_reg <= eeprom_link_pkg::st_mack;
							end else begin
								shift_reg <= {shift_reg[6:0], 1'b0};
								sda_oe_reg <= !shift_reg[6];
								bit_cnt_reg <= bit_cnt_reg + 4'h1;
							end
						end
					end
					eeprom_link_pkg::st_mack: begin
						if (scl_rise) begin
							more_reg <= !sda_s;
						end else if (scl_fall) begin
							bit_cnt_reg <= 4'h0;
							if (more_reg) begin
								shift_reg <= read_data;
								sda_oe_reg <= !read_data[7];
								read_data_strobe <= 1'b1;
								state_reg <= eeprom_link_pkg::st_tx;
							end else begin
								sda_oe_reg <= 1'b0;
								state_reg <= eeprom_link_pkg::st_idle;
							end
						end
					end
					default: begin
						sda_oe_reg <= 1'b0;
					end
				endcase
			end
		end
	end

	// programming cycle timer, started only by a stop after write data
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			prog_cnt_reg <= 32'h0;
			busy <= 1'b0;
			write_cycle_start <= 1'b0;
			write_blocked <= 1'b0;
		end else begin
			write_cycle_start <= 1'b0;
			write_blocked <= 1'b0;
			if (stop_seen && wrote_data_reg && !wp_s) begin
				busy <= 1'b1;
				prog_cnt_reg <= 32'h0;
				write_cycle_start <= 1'b1;
			end else if (stop_seen && wrote_data_reg) begin
				write_blocked <= 1'b1;
			end else if (busy) begin
				if (prog_cnt_reg == WRITE_CYCLE_CYCLES - 1) begin
					busy <= 1'b0;
				end
				prog_cnt_reg <= prog_cnt_reg + 32'h1;
			end
		end
	end

	// open drain: output level is always low, only the enable moves
	assign link.d_sda_out = 1'b0;
	assign link.d_sda_oe = sda_oe_reg;
endmodule
`default_nettype wire

// file: sim/eeprom_link_assertions.sv
// wire-level checks of the two-wire link between master and slave end
// assumes one clock domain and pull-ups modelled by the interface
`timescale 1ns/1ns
`default_nettype none
module eeprom_link_assertions (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic m_scl_out,
	input wire logic m_scl_oe,
	input wire logic m_sda_out,
	input wire logic m_sda_oe,
	input wire logic d_sda_out,
	input wire logic d_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	default clocking dc @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	// both ends may only pull low, never drive high
	a_slave_open_drain: assert property (d_sda_oe |-> !d_sda_out && !sda)
		else $error("slave drives sda high");
	a_master_open_drain: assert property ((m_sda_oe || m_scl_oe) |-> !m_sda_out && !m_scl_out
		&& (!m_sda_oe || !sda) && (!m_scl_oe || !scl))
		else $error("master drives a line high");
	// slave moves sda a few clocks after scl falls, never near scl high
	a_slave_moves_low: assert property ($changed(d_sda_oe) |-> !scl && !$past(scl, 2)
		&& ($past(scl, 4) || $past(scl, 5) || $past(scl, 6)))
		else $error("slave sda moved outside scl low");
	// a pulled-low ack stays low through the whole scl high phase
	a_ack_held_high: assert property (d_sda_oe && scl |=> d_sda_oe)
		else $error("slave released sda while scl high");
	// a stop leaves the slave off the line
	a_stop_releases: assert property ($rose(sda) && scl && $past(scl) |=> !d_sda_oe [*8])
		else $error("slave drives sda after stop");
	// a start is followed by scl low within 307 clocks, a quarter bit plus some margin
	a_start_clock_low: assert property ($fell(sda) && scl && $past(scl) |-> scl [*8] ##[1:300] !scl)
		else $error("no clock after start");
	// a start only comes out of an idle bus
	a_start_from_idle: assert property ($fell(sda) && scl && $past(scl)
		|-> $past(scl, 200) && $past(sda, 200))
		else $error("start without idle bus");
	// data stays put just after each scl rise
	a_data_high_hold: assert property ($rose(scl) |=> $stable(sda) [*8])
		else $error("sda moved after scl rise");
endmodule
`default_nettype wire

// file: sim/serial_eeprom_bus_slave_front_tb.sv
// bench: master end talks to the slave end over one link, results judged here
// assumes the link constants header; scl is made by the master divider
`include "eeprom_link_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module serial_eeprom_bus_slave_front_tb;
	logic clock;
	logic rst_n;
	logic cmd_valid;
	eeprom_link_pkg::bus_op_t cmd_op;
	logic [7:0] cmd_wdata;
	logic cmd_nack;
	logic cmd_ready;
	logic done;
	logic [7:0] read_byte;
	logic ack_seen;
	logic [`WORD_ADDR_W-1:0] word_address_bits;
	logic [`WORD_ADDR_W-1:0] wr_addr;
	logic [`WORD_ADDR_W-1:0] rd_addr;
	logic [7:0] write_data;
	logic [7:0] wr_byte;
	logic write_data_strobe;
	logic read_data_strobe;
	logic write_cycle_start;
	logic busy;
	logic [3:0] starts_seen;
	logic [3:0] blocks_seen;
	logic write_blocked;
	logic [2:0] sel_pins;
	logic wp_pin;
	int num_errors;
	int cmp_count;

	eeprom_link_if eeprom_link_if_i();
	eeprom_master_end eeprom_master_end_i(.clock(clock), .rst_n(rst_n), .link(eeprom_link_if_i),
		.cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_wdata(cmd_wdata), .cmd_nack(cmd_nack),
		.cmd_ready(cmd_ready), .done(done), .read_byte(read_byte), .ack_seen(ack_seen));
	// select pins and write-protect come from the bench; programming cycle kept short
	eeprom_slave_end #(.WRITE_CYCLE_CYCLES(12000)) eeprom_slave_end_i(.clock(clock), .rst_n(rst_n),
		.link(eeprom_link_if_i), .select_pin_low(sel_pins[0]), .select_pin_mid(sel_pins[1]),
		.select_pin_high(sel_pins[2]), .write_protect(wp_pin), .read_data(word_address_bits[7:0] ^ 8'h3c),
		.word_address_bits(word_address_bits), .write_data(write_data),
		.write_data_strobe(write_data_strobe), .read_data_strobe(read_data_strobe),
		.write_cycle_start(write_cycle_start), .write_blocked(write_blocked), .busy(busy));
	eeprom_link_assertions eeprom_link_assertions_i(.clock(clock), .rst_n(rst_n),
		.m_scl_out(eeprom_link_if_i.m_scl_out), .m_scl_oe(eeprom_link_if_i.m_scl_oe),
		.m_sda_out(eeprom_link_if_i.m_sda_out), .m_sda_oe(eeprom_link_if_i.m_sda_oe),
		.d_sda_out(eeprom_link_if_i.d_sda_out), .d_sda_oe(eeprom_link_if_i.d_sda_oe),
		.scl(eeprom_link_if_i.scl), .sda(eeprom_link_if_i.sda));

	// strobes last one cycle, so hold what they carried; read mid-cycle where they stand
	always @(negedge clock) begin
		if (!rst_n) begin
			starts_seen <= 4'h0;
			blocks_seen <= 4'h0;
		end else begin
			if (write_data_strobe) begin
				wr_byte <= write_data;
				wr_addr <= word_address_bits;
			end
			if (read_data_strobe)
				rd_addr <= word_address_bits;
			if (write_cycle_start)
				starts_seen <= starts_seen + 4'h1;
			if (write_blocked)
				blocks_seen <= blocks_seen + 4'h1;
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic give_verdict();
		$display("compares %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// one master command; valid dropped after the take so done cannot retrigger it
	task automatic run_op(input eeprom_link_pkg::bus_op_t op, input logic [7:0] d, input logic nk);
		int n;
		@(negedge clock);
		cmd_valid = 1'b1;
		cmd_op = op;
		cmd_wdata = d;
		cmd_nack = nk;
		@(negedge clock);
		cmd_valid = 1'b0;
		for (n = 0; n < 12000 && done !== 1'b1; n++)
			@(negedge clock);
		if (done !== 1'b1) begin
			num_errors++;
			$display("mismatch at %0t: master op hung", $time);
			give_verdict();
		end
	endtask

	task automatic send(input logic [7:0] d, input logic exp_ack);
		run_op(eeprom_link_pkg::op_write, d, 1'b0);
		check(ack_seen, exp_ack, "ack");
	endtask

	task automatic t_write();
		// protect high while bytes arrive, low at the stop
		wp_pin = 1'b1;
		run_op(eeprom_link_pkg::op_start, 8'h00, 1'b0);
		send({`DEV_TYPE_CODE, 3'h5, 1'b0}, 1'b1);
		send(8'hfa, 1'b1);
		send(8'h47, 1'b1);
		send(8'h96, 1'b1);
		check(wr_addr, 14'h3a47, "write address");
		check(wr_byte, 8'h96, "write data");
		check(word_address_bits, 14'h3a48, "next address");
		wp_pin = 1'b0;
		run_op(eeprom_link_pkg::op_stop, 8'h00, 1'b0);
		// protect raised once the cycle runs
		wp_pin = 1'b1;
		check(starts_seen, 4'h1, "write cycles");
		check(blocks_seen, 4'h0, "protect sampled at stop only");
		check(busy, 1'b1, "busy after stop");
		$display("test write done");
	endtask

	// control byte during programming must go unanswered
	task automatic t_poll();
		int n;
		run_op(eeprom_link_pkg::op_start, 8'h00, 1'b0);
		send({`DEV_TYPE_CODE, 3'h5, 1'b0}, 1'b0);
		check(busy, 1'b1, "busy while polled");
		run_op(eeprom_link_pkg::op_stop, 8'h00, 1'b0);
		for (n = 0; n < 20000 && busy !== 1'b0; n++)
			@(negedge clock);
		check(busy, 1'b0, "busy ends");
		if (busy !== 1'b0)
			give_verdict();
		check(starts_seen, 4'h1, "no cycle from refused write");
		check(blocks_seen, 4'h0, "late protect leaves cycle alone");
		$display("test poll done");
	endtask

	// protected write: acked and strobed, but the stop starts no cycle
	task automatic t_protect();
		run_op(eeprom_link_pkg::op_start, 8'h00, 1'b0);
		send({`DEV_TYPE_CODE, 3'h5, 1'b0}, 1'b1);
		send(8'h41, 1'b1);
		send(8'h22, 1'b1);
		send(8'h5a, 1'b1);
		check(wr_addr, 14'h0122, "protected address");
		check(wr_byte, 8'h5a, "protected data");
		run_op(eeprom_link_pkg::op_stop, 8'h00, 1'b0);
		check(blocks_seen, 4'h1, "write blocked");
		check(starts_seen, 4'h1, "no cycle under protect");
		check(busy, 1'b0, "idle after blocked stop");
		$display("test protect done");
	endtask

	// pinless strapping: wrong type, wrong low select bit, then a read under protect
	task automatic t_select_read();
		sel_pins = 3'h4;
		repeat (5) @(negedge clock);
		run_op(eeprom_link_pkg::op_start, 8'h00, 1'b0);
		send({~`DEV_TYPE_CODE, 3'h4, 1'b0}, 1'b0);
		run_op(eeprom_link_pkg::op_start, 8'h00, 1'b0);
		send({`DEV_TYPE_CODE, 3'h5, 1'b0}, 1'b0);
		run_op(eeprom_link_pkg::op_start, 8'h00, 1'b0);
		send({`DEV_TYPE_CODE, 3'h4, 1'b1}, 1'b1);
		run_op(eeprom_link_pkg::op_read, 8'h00, 1'b1);
		check(read_byte, 8'h23 ^ 8'h3c, "read byte");
		check(ack_seen, 1'b0, "sda left high at nack");
		check(rd_addr, 14'h0123, "read address");
		run_op(eeprom_link_pkg::op_stop, 8'h00, 1'b0);
		check(word_address_bits, 14'h0124, "address after read");
		$display("test select and read done");
	endtask

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	initial begin
		rst_n = 1'b0;
		cmd_valid = 1'b0;
		cmd_op = eeprom_link_pkg::op_start;
		cmd_wdata = 8'h00;
		cmd_nack = 1'b0;
		sel_pins = 3'h5;
		wp_pin = 1'b0;
		num_errors = 0;
		cmp_count = 0;
		repeat (20) @(negedge clock);
		rst_n = 1'b1;
		// idle bus for a few clocks so the slave sees the first start
		repeat (5) @(negedge clock);
		t_write();
		t_poll();
		t_protect();
		t_select_read();
		give_verdict();
	end
endmodule
`default_nettype wire
